// ==== rtl/uamd_buf2.sv ====
// two-entry receive buffer with registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "uamd_cfg.svh"
module uamd_buf2 #(
  parameter int WIDTH = `UAMD_BUF_WIDTH
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  logic [WIDTH-1:0] second;
  logic [1:0]       cnt;
  logic [1:0]       next_cnt;
  logic             push;
  logic             pop;

  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt         <= 2'h0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b1;
    end else begin
      cnt         <= next_cnt;
      out_valid_o <= next_cnt != 2'h0;
      in_ready_o  <= next_cnt != 2'h2;
    end
  end

  // head always holds the oldest word, so the output needs no mux
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o <= '0;
      second     <= '0;
    end else begin
      if (pop) begin
        out_data_o <= (cnt == 2'h2) ? second : in_data_i;
      end else if (push && cnt == 2'h0) begin
        out_data_o <= in_data_i;
      end
      if (push && ((cnt == 2'h1 && !pop) || cnt == 2'h2)) begin
        second <= in_data_i;
      end
    end
  end
endmodule // uamd_buf2
`default_nettype wire

// ==== rtl/uamd_cfg.svh ====
// constants of the multidrop, infrared, sleep and loopback uart block
`ifndef UAMD_CFG_SVH
`define UAMD_CFG_SVH
`define UAMD_TICKS_PER_BIT 16
`define UAMD_MID_TICK      4'h7
`define UAMD_LAST_TICK     4'hF
`define UAMD_IR10_WIDTH    4'h3
`define UAMD_IR11_WIDTH    4'h4
`define UAMD_IR_STRETCH    5'h10
`define UAMD_BUF_WIDTH     11
`define UAMD_TAG_PAR       8
`define UAMD_TAG_FRM       9
`define UAMD_TAG_BRK       10
`define UAMD_LCR_PEN       3
`define UAMD_LCR_EVEN      4
`define UAMD_LCR_STICK     5
`define UAMD_MCR_DTR       0
`define UAMD_MCR_RTS       1
`define UAMD_MCR_LOOP      4
`define UAMD_MCR_IR        6
`define UAMD_EXTRA_FEATURE_CTRL_REG_MD       0
`define UAMD_EXTRA_FEATURE_CTRL_REG_IR11     7
`define UAMD_EFR_SDET      5
`define UAMD_IER_LSI       2
`define UAMD_IER_SLEEP     4
`endif

// ==== rtl/uamd_ir_codec.sv ====
// infrared pulse encoder and decoder
`timescale 1ns/1ps
`default_nettype none
`include "uamd_cfg.svh"
module uamd_ir_codec (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       ir_en_i,
  input  wire logic       ir_v11_i,
  input  wire logic       tx_active_i,
  input  wire logic       tx_bit_i,
  input  wire logic [3:0] tx_phase_i,
  input  wire logic       rx_pin_i,
  output logic            enc_o,
  output logic            dec_o
);
  logic [3:0] width;
  logic [4:0] stretch;
  logic       rx_prev;

  assign width = ir_v11_i ? `UAMD_IR11_WIDTH : `UAMD_IR10_WIDTH;

  // a pulse only for a zero bit; idle and one bits leave the led dark
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enc_o <= 1'b0;
    end else if (tick_i) begin
      enc_o <= ir_en_i && tx_active_i && !tx_bit_i && (tx_phase_i < width);
    end
  end

  // each rising pulse edge yields a one on the decoded stream for a bit time
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_prev <= 1'b1;
      stretch <= 5'h00;
    end else begin
      rx_prev <= rx_pin_i;
      if (rx_pin_i && !rx_prev) begin
        stretch <= `UAMD_IR_STRETCH;
      end else if (tick_i && stretch != 5'h00) begin
        stretch <= stretch - 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_o <= 1'b0;
    end else begin
      dec_o <= ir_en_i && (stretch != 5'h00);
    end
  end
endmodule // uamd_ir_codec
`default_nettype wire

// ==== rtl/uamd_pkg.sv ====
// types of the multidrop, infrared, sleep and loopback uart block
package uamd_pkg;
  typedef enum logic [2:0] {
    UAMD_IDLE  = 3'b000,
    UAMD_START = 3'b001,
    UAMD_DATA  = 3'b010,
    UAMD_PAR   = 3'b011,
    UAMD_STOP  = 3'b100
  } uamd_bit_st_t;
endpackage

// ==== rtl/uamd_uart.sv ====
// uart core with multidrop, infrared, sleep and loopback modes
// Behaviour
// - multidrop on, special detect off: normal multidrop
// - multidrop uses forced parity zero: one means address
// - disabled receiver drops bytes with parity zero
// - address byte flags parity error, interrupt, always stored
// - both bits set: automatic address match mode
// - auto mode, disabled: drop data and mismatches
// - match enables receiver, stores byte, raises interrupt
// - enabled: mismatch address disables, match is stored
// - infrared 1.0: 3/16 bit pulse per zero
// - infrared 1.1: quarter bit pulse per zero
// - modem bit 6 infrared, feature bit 7 v1.1
// - infrared transmit output idles low
// - each sensed light pulse yields a zero
// - sleep needs idle int, enable, modem, rx high
// - asleep stops the oscillator output
// - wake on start edge, tx write, modem change
// - resleep after service; never with interrupt pending
// - modem status read clears change, allows sleep
// - sleep behaviour lasts until enable bit cleared
// - loopback routes tx shift into rx shift
// - loopback holds tx, rts, dtr; ignores modem inputs
// - three error tags ride with each byte
// - match compares only configured word length bits
`timescale 1ns/1ps
`default_nettype none
`include "uamd_cfg.svh"
module uamd_uart
  import uamd_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       baud_tick_i,
  input  wire logic [7:0] line_control_reg_i,
  input  wire logic [7:0] modem_control_reg_i,
  input  wire logic [7:0] extra_feature_ctrl_reg_i,
  input  wire logic [7:0] enhanced_function_reg_i,
  input  wire logic [7:0] interrupt_enable_reg_i,
  input  wire logic [7:0] match_char_two_i,
  input  wire logic       rx_enable_set_i,
  input  wire logic       rx_enable_clr_i,
  input  wire logic       line_status_read_i,
  input  wire logic       modem_status_read_i,
  input  wire logic       other_int_pending_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic [7:0]      rx_data_o,
  output logic [2:0]      rx_tags_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  input  wire logic       rx_i,
  input  wire logic [3:0] modem_n_i,
  output logic            tx_o,
  output logic            rts_n_o,
  output logic            dtr_n_o,
  output logic [3:0]      modem_state_o,
  output logic [3:0]      modem_delta_o,
  output logic            line_status_int_o,
  output logic            rx_enabled_o,
  output logic            asleep_o,
  output logic            oscillator_output_pin_run_o
);
  function automatic logic [7:0] wl_mask(input logic [1:0] wl);
    wl_mask = 8'hFF >> (2'h3 - wl);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_control_reg);
    logic p;
    p = ^(d & wl_mask(line_control_reg[1:0]));
    if (line_control_reg[`UAMD_LCR_STICK]) begin
      par_bit = !line_control_reg[`UAMD_LCR_EVEN];
    end else begin
      par_bit = line_control_reg[`UAMD_LCR_EVEN] ? p : !p;
    end
  endfunction

  logic md_en, md_norm, md_auto, ir_en, ir_v11, loop_en, sleep_en, par_en;
  logic [4:0] s1, s2, s3, filt;
  logic rx_line, ir_enc, ir_dec;
  uamd_bit_st_t tx_st, rx_st;
  logic [3:0] tx_cnt, rx_cnt;
  logic [2:0] tx_idx, rx_idx;
  logic [7:0] tx_sh, rx_sh;
  logic tx_ser, rx_par, rx_done, rx_frm;
  logic is_addr, match, do_push, do_en, do_dis, tag_par;
  logic [10:0] pend;
  logic pend_valid, pend_load, buf_ready;
  logic lsr_flag, pending, next_asleep;
  logic [2:0] wl_last;

  assign md_en    = extra_feature_ctrl_reg_i[`UAMD_EXTRA_FEATURE_CTRL_REG_MD];
  assign md_norm  = md_en && !enhanced_function_reg_i[`UAMD_EFR_SDET];
  assign md_auto  = md_en && enhanced_function_reg_i[`UAMD_EFR_SDET];
  assign ir_en    = modem_control_reg_i[`UAMD_MCR_IR];
  assign ir_v11   = ir_en && extra_feature_ctrl_reg_i[`UAMD_EXTRA_FEATURE_CTRL_REG_IR11];
  assign loop_en  = modem_control_reg_i[`UAMD_MCR_LOOP];
  assign sleep_en = interrupt_enable_reg_i[`UAMD_IER_SLEEP];
  assign par_en   = line_control_reg_i[`UAMD_LCR_PEN];
  assign wl_last  = {1'b1, line_control_reg_i[1:0]};

  // pin inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1   <= 5'h1F;
      s2   <= 5'h1F;
      s3   <= 5'h1F;
      filt <= 5'h1F;
    end else begin
      s1   <= {rx_i, modem_n_i};
      s2   <= s1;
      s3   <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
    end
  end

  // the receive shifter sees the transmit shifter, not the pin, in loopback
  assign rx_line = loop_en ? tx_ser : (ir_en ? !ir_dec : filt[4]);

  uamd_ir_codec u_ir (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .tick_i      (baud_tick_i),
    .ir_en_i     (ir_en),
    .ir_v11_i    (ir_v11),
    .tx_active_i (tx_st != UAMD_IDLE),
    .tx_bit_i    (tx_ser),
    .tx_phase_i  (tx_cnt),
    .rx_pin_i    (filt[4]),
    .enc_o       (ir_enc),
    .dec_o       (ir_dec)
  );

  // transmitter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st      <= UAMD_IDLE;
      tx_cnt     <= 4'h0;
      tx_idx     <= 3'h0;
      tx_sh      <= 8'h00;
      tx_ser     <= 1'b1;
      tx_ready_o <= 1'b1;
    end else if (tx_st == UAMD_IDLE) begin
      if (tx_valid_i && tx_ready_o) begin
        tx_sh      <= tx_data_i;
        tx_st      <= UAMD_START;
        tx_cnt     <= 4'h0;
        tx_ser     <= 1'b0;
        tx_ready_o <= 1'b0;
      end
    end else if (baud_tick_i) begin
      tx_cnt <= tx_cnt + 4'h1;
      if (tx_cnt == `UAMD_LAST_TICK) begin
        case (tx_st)
          UAMD_START: begin
            tx_st  <= UAMD_DATA;
            tx_idx <= 3'h0;
            tx_ser <= tx_sh[0];
          end
          UAMD_DATA: begin
            if (tx_idx == wl_last) begin
              tx_st  <= par_en ? UAMD_PAR : UAMD_STOP;
              tx_ser <= par_en ? par_bit(tx_sh, line_control_reg_i) : 1'b1;
            end else begin
              tx_idx <= tx_idx + 3'h1;
              tx_ser <= tx_sh[tx_idx+3'h1];
            end
          end
          UAMD_PAR: begin
            tx_st  <= UAMD_STOP;
            tx_ser <= 1'b1;
          end
          default: begin
            tx_st      <= UAMD_IDLE;
            tx_ready_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // receiver; sampling lands mid-bit, sixteen ticks apart
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st   <= UAMD_IDLE;
      rx_cnt  <= 4'h0;
      rx_idx  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_par  <= 1'b0;
      rx_frm  <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (baud_tick_i) begin
        rx_cnt <= rx_cnt + 4'h1;
        case (rx_st)
          UAMD_IDLE: begin
            rx_cnt <= 4'h0;
            if (!rx_line) begin
              rx_st <= UAMD_START;
            end
          end
          UAMD_START: begin
            if (rx_cnt == `UAMD_MID_TICK) begin
              rx_cnt <= 4'h0;
              rx_idx <= 3'h0;
              rx_sh  <= 8'h00;
              rx_par <= 1'b0;
              rx_st  <= rx_line ? UAMD_IDLE : UAMD_DATA;
            end
          end
          UAMD_DATA: begin
            if (rx_cnt == `UAMD_LAST_TICK) begin
              rx_sh[rx_idx] <= rx_line;
              rx_idx        <= rx_idx + 3'h1;
              if (rx_idx == wl_last) begin
                rx_st <= (par_en || md_en) ? UAMD_PAR : UAMD_STOP;
              end
            end
          end
          UAMD_PAR: begin
            if (rx_cnt == `UAMD_LAST_TICK) begin
              rx_par <= rx_line;
              rx_st  <= UAMD_STOP;
            end
          end
          default: begin
            if (rx_cnt == `UAMD_LAST_TICK) begin
              rx_frm  <= !rx_line;
              rx_done <= 1'b1;
              rx_st   <= UAMD_IDLE;
            end
          end
        endcase
      end
    end
  end

  // address filter
  assign is_addr = md_en && rx_par;
  assign match   = ((rx_sh ^ match_char_two_i) & wl_mask(line_control_reg_i[1:0])) == 8'h00;
  always_comb begin
    do_push = 1'b0;
    do_en   = 1'b0;
    do_dis  = 1'b0;
    tag_par = par_en && (rx_par != par_bit(rx_sh, line_control_reg_i));
    if (md_norm) begin
      tag_par = rx_par;
      do_push = rx_par || rx_enabled_o;
    end else if (md_auto) begin
      tag_par = rx_par;
      if (is_addr && match) begin
        do_push = 1'b1;
        do_en   = 1'b1;
      end else if (is_addr) begin
        do_dis  = 1'b1;
      end else begin
        do_push = rx_enabled_o;
      end
    end else begin
      do_push = rx_enabled_o;
    end
  end

  // one word waits for the buffer; a word finishing while one waits on a full buffer is lost
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend       <= 11'h000;
      pend_valid <= 1'b0;
      pend_load  <= 1'b0;
    end else begin
      pend_load <= rx_done && do_push && (!pend_valid || buf_ready);
      if (rx_done && do_push && (!pend_valid || buf_ready)) begin
        pend       <= {rx_frm && rx_sh == 8'h00 && !rx_par, rx_frm, tag_par, rx_sh};
        pend_valid <= 1'b1;
      end else if (buf_ready) begin
        pend_valid <= 1'b0;
      end
    end
  end

  uamd_buf2 #(.WIDTH(`UAMD_BUF_WIDTH)) u_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (pend),
    .in_valid_i  (pend_valid),
    .in_ready_o  (buf_ready),
    .out_data_o  ({rx_tags_o, rx_data_o}),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );

  // receiver enable flag: hardware changes win over a software write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_enabled_o <= 1'b0;
    end else if (rx_done && md_auto && do_en) begin
      rx_enabled_o <= 1'b1;
    end else if (rx_done && md_auto && do_dis) begin
      rx_enabled_o <= 1'b0;
    end else if (rx_enable_set_i) begin
      rx_enabled_o <= 1'b1;
    end else if (rx_enable_clr_i) begin
      rx_enabled_o <= 1'b0;
    end
  end

  // line status interrupt: a new event in the clearing cycle survives
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lsr_flag <= 1'b0;
    end else if (rx_done && do_push && (is_addr || tag_par || rx_frm)) begin
      lsr_flag <= 1'b1;
    end else if (line_status_read_i) begin
      lsr_flag <= 1'b0;
    end
  end
  assign line_status_int_o = lsr_flag;

  // modem inputs are frozen and ignored during loopback
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      modem_state_o <= 4'h0;
      modem_delta_o <= 4'h0;
    end else if (!loop_en) begin
      modem_state_o <= ~filt[3:0];
      if (~filt[3:0] != modem_state_o) begin
        modem_delta_o <= modem_delta_o | (~filt[3:0] ^ modem_state_o);
      end else if (modem_status_read_i) begin
        modem_delta_o <= 4'h0;
      end
    end else if (modem_status_read_i) begin
      modem_delta_o <= 4'h0;
    end
  end

  // line outputs; held at their last level through loopback
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_o    <= 1'b1;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else if (!loop_en) begin
      tx_o    <= ir_en ? ir_enc : tx_ser;
      rts_n_o <= !modem_control_reg_i[`UAMD_MCR_RTS];
      dtr_n_o <= !modem_control_reg_i[`UAMD_MCR_DTR];
    end
  end

  // sleep; busy shifters and a waiting write also keep the clock running
  assign pending = (lsr_flag && interrupt_enable_reg_i[`UAMD_IER_LSI]) || other_int_pending_i;
  assign next_asleep = sleep_en && !pending && modem_delta_o == 4'h0 && filt[4] && !tx_valid_i
                       && tx_st == UAMD_IDLE && rx_st == UAMD_IDLE && !pend_valid;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      asleep_o                    <= 1'b0;
      oscillator_output_pin_run_o <= 1'b1;
    end else begin
      asleep_o                    <= next_asleep;
      oscillator_output_pin_run_o <= !next_asleep;
    end
  end

  logic [3:0] ir_hi;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_hi <= 4'h0;
    end else if (!ir_enc) begin
      ir_hi <= 4'h0;
    end else if (baud_tick_i) begin
      ir_hi <= ir_hi + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  md_drop_a: assert property (rx_done && md_norm && !rx_enabled_o && !rx_par |=> !pend_load)
    else $error("disabled multidrop receiver stored a data byte");
  md_addr_a: assert property (rx_done && md_norm && rx_par && (!pend_valid || buf_ready)
    |=> pend_load && pend[`UAMD_TAG_PAR] && lsr_flag)
    else $error("address byte not stored with parity tag and interrupt");
  auto_drop_a: assert property (rx_done && md_auto && !rx_enabled_o && !(rx_par && match)
    |=> !pend_load && !rx_enabled_o)
    else $error("auto mode kept a foreign byte");
  auto_match_a: assert property (rx_done && md_auto && rx_par && match && (!pend_valid || buf_ready)
    |=> rx_enabled_o && pend_load && pend[`UAMD_TAG_PAR] && lsr_flag)
    else $error("matching address did not enable and store");
  auto_dis_a: assert property (rx_done && md_auto && rx_enabled_o && rx_par && !match
    |=> !rx_enabled_o && !pend_load)
    else $error("mismatched address did not disable receiver");
  ir10_width_a: assert property ($fell(ir_enc) && !ir_v11 && $past(ir_en) |-> ir_hi == 4'h3)
    else $error("infrared 1.0 pulse not three ticks");
  ir11_width_a: assert property ($fell(ir_enc) && ir_v11 && $past(ir_v11) |-> ir_hi == 4'h4)
    else $error("infrared 1.1 pulse not four ticks");
  sleep_cond_a: assert property ($rose(asleep_o) |-> $past(sleep_en && !pending && filt[4]
    && modem_delta_o == 4'h0))
    else $error("sleep entered without all conditions");
  no_sleep_int_a: assert property (pending || !sleep_en |=> !asleep_o && oscillator_output_pin_run_o)
    else $error("asleep with interrupt pending");
  wake_tx_a: assert property (asleep_o && tx_valid_i |=> !asleep_o ##1 !tx_ready_o)
    else $error("transmit write did not wake");
  loop_hold_a: assert property (loop_en && $past(loop_en) |-> $stable(tx_o) && $stable(rts_n_o))
    else $error("line outputs moved during loopback");

  auto_match_c: cover property (rx_done && md_auto && rx_par && match ##1 rx_enabled_o);
  norm_addr_c: cover property (rx_done && md_norm && rx_par);
  sleep_c: cover property ($rose(asleep_o) ##[1:200] $fell(asleep_o));
  ir_pulse_c: cover property ($fell(ir_enc) && ir_en);
endmodule // uamd_uart
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the multidrop, infrared, sleep and loopback uart
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, baud_tick_i = 1'b0, rx_i, busy, send = 1'b0;
  logic rx_enable_set_i = 1'b0, rx_enable_clr_i = 1'b0, line_status_read_i = 1'b0;
  logic modem_status_read_i = 1'b0, other_int_pending_i = 1'b0, tx_valid_i = 1'b0;
  logic rx_ready_i = 1'b1, tx_moved = 1'b0, prev_tx = 1'b0;
  logic [7:0] line_control_reg_i = 8'h3B, modem_control_reg_i = 8'h00, tx_data_i = 8'h00;
  logic [7:0] extra_feature_ctrl_reg_i = 8'h01, enhanced_function_reg_i = 8'h00;
  logic [7:0] interrupt_enable_reg_i = 8'h00, match_char_two_i = 8'h5A, rx_data_o;
  logic [8:0] frame = 9'h000;
  logic [3:0] modem_n_i = 4'hF, modem_state_o, modem_delta_o;
  logic [2:0] rx_tags_o;
  logic tx_ready_o, rx_valid_o, tx_o, rts_n_o, dtr_n_o, line_status_int_o, rx_enabled_o;
  logic asleep_o, oscillator_output_pin_run_o;
  logic [10:0] got[$];
  int mismatches = 0, n_compared = 0, tick_cnt = 0, hi_cnt = 0, rises = 0;

  uamd_uart DUT (.ref_clk_i, .rst_n_i, .baud_tick_i, .line_control_reg_i, .modem_control_reg_i,
    .extra_feature_ctrl_reg_i, .enhanced_function_reg_i, .interrupt_enable_reg_i,
    .match_char_two_i, .rx_enable_set_i, .rx_enable_clr_i, .line_status_read_i,
    .modem_status_read_i, .other_int_pending_i, .tx_data_i, .tx_valid_i, .tx_ready_o,
    .rx_data_o, .rx_tags_o, .rx_valid_o, .rx_ready_i, .rx_i, .modem_n_i, .tx_o, .rts_n_o,
    .dtr_n_o, .modem_state_o, .modem_delta_o, .line_status_int_o, .rx_enabled_o,
    .asleep_o, .oscillator_output_pin_run_o);
  uamd_station far_end (.ref_clk_i, .tick_i(baud_tick_i), .send_i(send), .frame_i(frame),
    .line_o(rx_i), .busy_o(busy));

  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  // a tick every fourth cycle keeps a frame short: one bit is 64 cycles
  always @(negedge ref_clk_i) begin
    tick_cnt <= (tick_cnt + 1) % 4;
    baud_tick_i <= (tick_cnt == 3);
  end
  always @(posedge ref_clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i) got.push_back({rx_tags_o, rx_data_o});
    if (tx_o !== 1'b1) tx_moved <= 1'b1;
    hi_cnt <= hi_cnt + (tx_o === 1'b1);
    rises <= rises + (tx_o === 1'b1 && prev_tx === 1'b0);
    prev_tx <= tx_o;
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // software strobes: receiver set, receiver clear, line status read, modem status read
  task automatic sw(input logic [3:0] p);
    cyc(1);
    {rx_enable_set_i, rx_enable_clr_i, line_status_read_i, modem_status_read_i} = p;
    cyc(1);
    {rx_enable_set_i, rx_enable_clr_i, line_status_read_i, modem_status_read_i} = 4'h0;
  endtask
  task automatic kick(input logic [8:0] f);
    cyc(1);
    frame = f;
    send = 1'b1;
    cyc(1);
    send = 1'b0;
  endtask
  task automatic station(input logic [8:0] f);
    kick(f);
    for (int i = 0; i < 2000 && busy; i++) cyc(1);
    cyc(100);
  endtask
  task automatic pop(input logic [10:0] exp);
    logic [10:0] w;
    w = 'x;
    if (got.size() > 0) w = got.pop_front();
    check(w, exp);
  endtask
  // ready is seen high at a falling edge, so the next rising edge takes the byte
  task automatic send_tx(input logic [7:0] b);
    cyc(1);
    for (int i = 0; i < 2000 && tx_ready_o !== 1'b1; i++) cyc(1);
    tx_data_i = b;
    tx_valid_i = 1'b1;
    cyc(1);
    tx_valid_i = 1'b0;
  endtask
  task automatic wait_tx();
    for (int i = 0; i < 2000 && tx_ready_o !== 1'b1; i++) cyc(1);
    cyc(10);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    mismatches++;
    final_report();
  end

  initial begin
    cyc(10);
    rst_n_i = 1'b1;
    check({rx_valid_o, rx_enabled_o, asleep_o, oscillator_output_pin_run_o, tx_o}, 5'h03);
    station(9'h055);
    check(11'(got.size()), 11'h000);
    station(9'h1A5);
    pop(11'h1A5);
    check(line_status_int_o, 1'b1);
    sw(4'h2);
    sw(4'h8);
    check(rx_enabled_o, 1'b1);
    rx_ready_i = 1'b0;
    station(9'h011);
    station(9'h022);
    rx_ready_i = 1'b1;
    cyc(10);
    pop(11'h011);
    pop(11'h022);
    check(line_status_int_o, 1'b0);
    enhanced_function_reg_i = 8'h20;
    sw(4'h4);
    station(9'h1A5);
    station(9'h033);
    check(11'(got.size()), 11'h000);
    station(9'h15A);
    check(rx_enabled_o, 1'b1);
    pop(11'h15A);
    check(line_status_int_o, 1'b1);
    station(9'h044);
    station(9'h15A);
    station(9'h1A5);
    check(rx_enabled_o, 1'b0);
    pop(11'h044);
    pop(11'h15A);
    check(11'(got.size()), 11'h000);
    extra_feature_ctrl_reg_i = 8'h00;
    enhanced_function_reg_i = 8'h00;
    line_control_reg_i = 8'h03;
    modem_control_reg_i = 8'h03;
    sw(4'h8);
    modem_control_reg_i = 8'h13;
    sw(4'h1);
    tx_moved = 1'b0;
    modem_n_i = 4'h0;
    send_tx(8'hC3);
    wait_tx();
    cyc(100);
    pop(11'h0C3);
    check({tx_moved, rts_n_o, dtr_n_o, modem_delta_o}, 7'h00);
    modem_n_i = 4'hF;
    for (int v = 0; v < 2; v++) begin
      extra_feature_ctrl_reg_i = v ? 8'h80 : 8'h00;
      modem_control_reg_i = 8'h40;
      cyc(10);
      check(tx_o, 1'b0);
      hi_cnt = 0;
      rises = 0;
      send_tx(8'h00);
      wait_tx();
      check(11'(rises), 11'h009);
      check(11'(hi_cnt), v ? 11'h090 : 11'h06C);
    end
    modem_control_reg_i = 8'h00;
    extra_feature_ctrl_reg_i = 8'h00;
    interrupt_enable_reg_i = 8'h10;
    sw(4'h3);
    cyc(20);
    check({asleep_o, oscillator_output_pin_run_o}, 2'b10);
    other_int_pending_i = 1'b1;
    cyc(3);
    check(asleep_o, 1'b0);
    other_int_pending_i = 1'b0;
    modem_n_i = 4'hE;
    cyc(20);
    check({asleep_o, modem_delta_o != 4'h0}, 2'b01);
    sw(4'h1);
    cyc(5);
    check(asleep_o, 1'b1);
    send_tx(8'hFF);
    check(asleep_o, 1'b0);
    wait_tx();
    cyc(20);
    check(asleep_o, 1'b1);
    kick(9'h1FF);
    cyc(10);
    check(asleep_o, 1'b0);
    cyc(900);
    check(asleep_o, 1'b1);
    interrupt_enable_reg_i = 8'h00;
    cyc(3);
    check(asleep_o, 1'b0);
    final_report();
  end
endmodule // tb
`default_nettype wire

// ==== testbench/uamd_station.sv ====
// remote serial station driving frames onto the receive line
`timescale 1ns/1ps
`default_nettype none
module uamd_station (
  input  wire logic       ref_clk_i,
  input  wire logic       tick_i,
  input  wire logic       send_i,
  input  wire logic [8:0] frame_i,
  output logic            line_o,
  output logic            busy_o
);
  logic [10:0] shift;
  int          cnt;
  initial busy_o = 1'b0;
  // start bit, data lsb first, parity slot marks an address, stop bit
  always @(posedge ref_clk_i) begin
    if (send_i && !busy_o) begin
      shift  <= {1'b1, frame_i, 1'b0};
      cnt    <= 0;
      busy_o <= 1'b1;
    end else if (busy_o && tick_i) begin
      busy_o <= (cnt != 175);
      cnt    <= cnt + 1;
    end
  end
  // marking between frames, so the receiver never sees a break
  assign line_o = busy_o ? shift[cnt / 16] : 1'b1;
endmodule // uamd_station
`default_nettype wire
